// *** hw/anxp_regs.sv ***
// Autonegotiation expansion status and extra-page transmit registers
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Set fault when several technologies see link
// - Fault stays set until status read
// - Report partner extra-page support read-only
// - Local extra-page capability always reads one
// - Set page flag when extra page arrives
// - Report partner autonegotiation capability read-only
// - More-pages bit: zero last, one more
// - Acknowledge bit read-only, from link word
// - Selector: zero unformatted, one message page
// - Comply bit: one complies, zero cannot
// - Toggle opposes previous exchanged toggle value
// - First page toggle inverts base bit 11
module anxp_regs
  import anxp_pkg::*;
#(
  parameter int N_TECH = 3
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic IRQ,
  input wire logic PD_ACTIVE,
  input wire logic [N_TECH-1:0] TECH_LINK_OK,
  input wire logic PAGE_RX,
  input wire logic NP_START,
  input wire logic PAGE_DONE,
  input wire anxp_link_status_type LINK_STATUS,
  output logic [15:0] TX_PAGE
);

  // ==========================================================================
  // Types and helpers
  typedef struct packed {
    logic [15:0] rdata;
    logic irq;
    logic more_pages;
    logic message_page;
    logic comply_flag;
    logic [10:0] message_code_field;
    logic [1:0] irq_mask;
    logic [15:0] tx_page;
  } anxp_regs_state_type;

  // Address match for one register offset
  function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] off);
    reg_hit = (a == off);
  endfunction

  // True when two or more bits of the vector are set
  function automatic logic multi_hot(input logic [N_TECH-1:0] v);
    int cnt;
    cnt = 0;
    for (int i = 0; i < N_TECH; i++) begin
      cnt = cnt + int'(v[i]);
    end
    multi_hot = (cnt > 1);
  endfunction

  anxp_bus_req_type req;
  anxp_regs_state_type state;
  anxp_regs_state_type next_state;

  logic [ANXP_EV_W-1:0] latch_set;
  logic [ANXP_EV_W-1:0] latch_clr;
  logic [ANXP_EV_W-1:0] latch_q;
  logic [ANXP_EV_W-1:0] irq_clr;
  logic [ANXP_EV_W-1:0] irq_q;
  logic toggle;
  logic fault_now;
  logic exp_read;
  logic [15:0] exp_word;
  logic [15:0] tx_word;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // ==========================================================================
  // Event detection
  always_comb begin
    fault_now = PD_ACTIVE && multi_hot(TECH_LINK_OK);
    latch_set = '0;
    latch_set[ANXP_EV_FAULT] = fault_now;
    latch_set[ANXP_EV_PAGE] = PAGE_RX;
  end

  // ==========================================================================
  // Latching status bits, cleared by reading the expansion register
  always_comb begin
    exp_read = req.rd && reg_hit(req.addr, ANXP_OFF_EXPANSION);
    latch_clr = {ANXP_EV_W{exp_read}};
  end

  anxp_sticky #(
    .W(ANXP_EV_W)
  ) u_latch (
    .clk(CLK),
    .rst_n(RST_N),
    .set(latch_set),
    .clr(latch_clr),
    .q(latch_q)
  );

  // ==========================================================================
  // Interrupt status, write one to clear
  always_comb begin
    irq_clr = '0;
    if (req.wr && reg_hit(req.addr, ANXP_OFF_IRQ_STATUS)) begin
      irq_clr = req.wdata[ANXP_EV_W-1:0];
    end
  end

  anxp_sticky #(
    .W(ANXP_EV_W)
  ) u_irq (
    .clk(CLK),
    .rst_n(RST_N),
    .set(latch_set),
    .clr(irq_clr),
    .q(irq_q)
  );

  // ==========================================================================
  // Toggle tracking for outgoing pages
  anxp_toggle u_toggle (
    .clk(CLK),
    .rst_n(RST_N),
    .start(NP_START),
    .base_bit11(LINK_STATUS.base_bit11),
    .page_done(PAGE_DONE),
    .toggle(toggle)
  );

  // ==========================================================================
  // Read views of the two documented registers
  always_comb begin
    exp_word = 16'h0000;
    exp_word[ANXP_EXP_FAULT_BIT] = latch_q[ANXP_EV_FAULT];
    exp_word[ANXP_EXP_PARTNER_NP_BIT] = LINK_STATUS.partner_extra_page_support;
    exp_word[ANXP_EXP_LOCAL_NP_BIT] = ANXP_LOCAL_NP_ABLE;
    exp_word[ANXP_EXP_PAGE_BIT] = latch_q[ANXP_EV_PAGE];
    exp_word[ANXP_EXP_PARTNER_AN_BIT] = LINK_STATUS.partner_autoneg_capable;
  end

  always_comb begin
    tx_word = 16'h0000;
    tx_word[ANXP_TX_MORE_BIT] = state.more_pages;
    tx_word[ANXP_TX_ACK_BIT] = LINK_STATUS.lcw_ack;
    tx_word[ANXP_TX_MSG_BIT] = state.message_page;
    tx_word[ANXP_TX_COMPLY_BIT] = state.comply_flag;
    tx_word[ANXP_TX_TOGGLE_BIT] = toggle;
    tx_word[ANXP_TX_CODE_W-1:0] = state.message_code_field;
  end

  // ==========================================================================
  // Next state: register writes, read data, interrupt and outgoing word
  always_comb begin
    next_state = state;
    next_state.rdata = 16'h0000;

    if (req.wr && reg_hit(req.addr, ANXP_OFF_EXTRA_PAGE)) begin
      next_state.more_pages = req.wdata[ANXP_TX_MORE_BIT];
      next_state.message_page = req.wdata[ANXP_TX_MSG_BIT];
      next_state.comply_flag = req.wdata[ANXP_TX_COMPLY_BIT];
      next_state.message_code_field = req.wdata[ANXP_TX_CODE_W-1:0];
    end

    if (req.wr && reg_hit(req.addr, ANXP_OFF_IRQ_MASK)) begin
      next_state.irq_mask = req.wdata[ANXP_EV_W-1:0];
    end

    if (req.rd) begin
      unique case (1'h1)
        reg_hit(req.addr, ANXP_OFF_EXPANSION): begin
          next_state.rdata = exp_word;
        end
        reg_hit(req.addr, ANXP_OFF_EXTRA_PAGE): begin
          next_state.rdata = tx_word;
        end
        reg_hit(req.addr, ANXP_OFF_IRQ_STATUS): begin
          next_state.rdata = {14'h0, irq_q};
        end
        reg_hit(req.addr, ANXP_OFF_IRQ_MASK): begin
          next_state.rdata = {14'h0, state.irq_mask};
        end
        default: begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end

    next_state.irq = |(irq_q & state.irq_mask);
    next_state.tx_page = tx_word;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state.rdata <= 16'h0000;
      state.irq <= 1'h0;
      state.more_pages <= ANXP_RST_EXTRA_PAGE[ANXP_TX_MORE_BIT];
      state.message_page <= ANXP_RST_EXTRA_PAGE[ANXP_TX_MSG_BIT];
      state.comply_flag <= ANXP_RST_EXTRA_PAGE[ANXP_TX_COMPLY_BIT];
      state.message_code_field <= ANXP_RST_EXTRA_PAGE[ANXP_TX_CODE_W-1:0];
      state.irq_mask <= ANXP_RST_IRQ_MASK;
      state.tx_page <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops
  assign RDATA = state.rdata;
  assign IRQ = state.irq;
  assign TX_PAGE = state.tx_page;

endmodule // anxp_regs

`default_nettype wire

// *** hw/anxp_sticky.sv ***
// Sticky flag vector where a set in the same cycle as a clear wins
`timescale 1ns/1ns
`default_nettype none

module anxp_sticky #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);

  logic [W-1:0] next_q;

  // ==========================================================================
  // Next state: clear first, then set, so a set is never lost
  always_comb begin
    next_q = (q & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule // anxp_sticky

`default_nettype wire

// *** hw/anxp_toggle.sv ***
// Toggle bit tracker for outgoing extra pages
`timescale 1ns/1ns
`default_nettype none

module anxp_toggle (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic base_bit11,
  input wire logic page_done,
  output logic toggle
);

  typedef struct packed {
    logic toggle;
  } anxp_toggle_state_type;

  anxp_toggle_state_type state;
  anxp_toggle_state_type next_state;

  // ==========================================================================
  // Next state
  always_comb begin
    next_state = state;
    if (start) begin
      next_state.toggle = ~base_bit11;
    end else if (page_done) begin
      next_state.toggle = ~state.toggle;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign toggle = state.toggle;

endmodule // anxp_toggle

`default_nettype wire

// *** shared/anxp_pkg.sv ***
// Package: offsets, field layout, reset values and carrier types of the extra-page register bank
package anxp_pkg;

  // ==========================================================================
  // Register offsets
  localparam int ANXP_ADDR_W = 5;
  localparam logic [4:0] ANXP_OFF_EXPANSION = 5'h06;
  localparam logic [4:0] ANXP_OFF_EXTRA_PAGE = 5'h07;
  localparam logic [4:0] ANXP_OFF_IRQ_STATUS = 5'h08;
  localparam logic [4:0] ANXP_OFF_IRQ_MASK = 5'h09;

  // ==========================================================================
  // Expansion status field positions
  localparam int ANXP_EXP_FAULT_BIT = 4;
  localparam int ANXP_EXP_PARTNER_NP_BIT = 3;
  localparam int ANXP_EXP_LOCAL_NP_BIT = 2;
  localparam int ANXP_EXP_PAGE_BIT = 1;
  localparam int ANXP_EXP_PARTNER_AN_BIT = 0;

  // ==========================================================================
  // Extra-page transmit field positions
  localparam int ANXP_TX_MORE_BIT = 15;
  localparam int ANXP_TX_ACK_BIT = 14;
  localparam int ANXP_TX_MSG_BIT = 13;
  localparam int ANXP_TX_COMPLY_BIT = 12;
  localparam int ANXP_TX_TOGGLE_BIT = 11;
  localparam int ANXP_TX_CODE_W = 11;

  // ==========================================================================
  // Event bit positions, shared by latches, interrupt status and mask
  localparam int ANXP_EV_FAULT = 0;
  localparam int ANXP_EV_PAGE = 1;
  localparam int ANXP_EV_W = 2;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] ANXP_RST_EXTRA_PAGE = 16'h0000;
  localparam logic [1:0] ANXP_RST_IRQ_MASK = 2'h0;
  localparam logic ANXP_LOCAL_NP_ABLE = 1'h1;

  // ==========================================================================
  // Link status levels from the autonegotiation engine
  typedef struct packed {
    logic partner_extra_page_support;
    logic partner_autoneg_capable;
    logic lcw_ack;
    logic base_bit11;
  } anxp_link_status_type;

  // Register bus request
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } anxp_bus_req_type;

endpackage : anxp_pkg

// *** sim/anxp_engine_model.sv ***
// Behavioural autonegotiation engine driving the link side of the register bank
`timescale 1ns/1ns
`default_nettype none

module anxp_engine_model
  import anxp_pkg::*;
(
  input wire logic clk,
  output logic pd_active,
  output logic [2:0] tech_link_ok,
  output logic page_rx,
  output logic np_start,
  output logic page_done,
  output var anxp_link_status_type link_status
);
  initial begin
    pd_active = 1'b0;
    tech_link_ok = 3'h0;
    {page_rx, np_start, page_done} = 3'h0;
    link_status = '0;
  end

  // ==========
  // Engine actions
  // Drive all four link status levels, including base word bit 11
  task automatic set_status(input anxp_link_status_type s);
    link_status <= s;
    @(posedge clk);
    #1;
  endtask

  // One-cycle strobes: page arrived, exchange start, page exchanged
  task automatic pulse(input logic [2:0] p);
    {page_rx, np_start, page_done} <= p;
    @(posedge clk);
    {page_rx, np_start, page_done} <= 3'h0;
    #1;
  endtask

  // Parallel detection sees the given technologies linked for one cycle
  task automatic detect(input logic pd, input logic [2:0] t);
    pd_active <= pd;
    tech_link_ok <= t;
    @(posedge clk);
    pd_active <= 1'b0;
    tech_link_ok <= 3'h0;
    #1;
  endtask
endmodule // anxp_engine_model

`default_nettype wire

// *** sim/anxp_regs_sva.sv ***
// Port-level assertions for the extra-page register bank
`timescale 1ns/1ns
`default_nettype none

module anxp_regs_sva
  import anxp_pkg::*;
#(
  parameter int N_TECH = 3
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic IRQ,
  input wire logic PD_ACTIVE,
  input wire logic [N_TECH-1:0] TECH_LINK_OK,
  input wire logic PAGE_RX,
  input wire logic NP_START,
  input wire logic PAGE_DONE,
  input wire anxp_link_status_type LINK_STATUS,
  input wire logic [15:0] TX_PAGE
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  logic rd6;
  logic ev;
  assign rd6 = RD && (ADDR == ANXP_OFF_EXPANSION);
  assign ev = PAGE_RX || (PD_ACTIVE && ($countones(TECH_LINK_OK) > 1));

  // ==========
  // Expansion status
  chk_local_np_one: assert property (rd6 |=> RDATA[2])
    else $error("local extra-page bit not one");
  chk_reserved_zero: assert property (rd6 |=> RDATA[15:5] == 11'h000)
    else $error("reserved status bits not zero");
  chk_partner_np: assert property (rd6 |=> RDATA[3] == $past(LINK_STATUS.partner_extra_page_support))
    else $error("partner extra-page bit wrong");
  chk_partner_an: assert property (rd6 |=> RDATA[0] == $past(LINK_STATUS.partner_autoneg_capable))
    else $error("partner autoneg bit wrong");
  chk_fault_latch: assert property (PD_ACTIVE && $countones(TECH_LINK_OK) > 1 ##1 rd6 |=> RDATA[4])
    else $error("fault not latched");
  chk_page_latch: assert property (PAGE_RX ##1 rd6 |=> RDATA[1])
    else $error("page flag not latched");
  chk_read_clears: assert property ((rd6 && !ev) ##1 (rd6 && !ev) |=> !RDATA[4] && !RDATA[1])
    else $error("latched bits survive a read");

  // ==========
  // Extra-page word
  chk_ack_live: assert property ($stable(LINK_STATUS.lcw_ack) [*3] |-> TX_PAGE[14] == LINK_STATUS.lcw_ack)
    else $error("acknowledge bit not from link word");
  chk_first_toggle: assert property (NP_START |-> ##2 TX_PAGE[11] == !$past(LINK_STATUS.base_bit11, 2))
    else $error("first toggle not inverse of base bit");
  chk_toggle_flip: assert property (PAGE_DONE && !NP_START |-> ##2 TX_PAGE[11] != $past(TX_PAGE[11]))
    else $error("toggle did not flip");
  chk_tx_fields: assert property (WR && ADDR == ANXP_OFF_EXTRA_PAGE |-> ##2
    {TX_PAGE[15], TX_PAGE[13:12], TX_PAGE[10:0]} == $past({WDATA[15], WDATA[13:12], WDATA[10:0]}, 2))
    else $error("written fields not sent");

  cover property (rd6 ##1 rd6);
  cover property (NP_START ##[1:20] PAGE_DONE);
  cover property ($rose(IRQ));
endmodule // anxp_regs_sva

bind anxp_regs anxp_regs_sva #(.N_TECH(N_TECH)) i_anxp_regs_sva (.CLK(CLK), .RST_N(RST_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
  .PD_ACTIVE(PD_ACTIVE), .TECH_LINK_OK(TECH_LINK_OK), .PAGE_RX(PAGE_RX), .NP_START(NP_START),
  .PAGE_DONE(PAGE_DONE), .LINK_STATUS(LINK_STATUS), .TX_PAGE(TX_PAGE));

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the extra-page register bank
`timescale 1ns/1ns
`default_nettype none

module tb;
  import anxp_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, IRQ;
  logic [4:0] ADDR = 5'h00;
  logic [15:0] WDATA = 16'h0000, RDATA, TX_PAGE, d;
  logic PD_ACTIVE, PAGE_RX, NP_START, PAGE_DONE;
  logic [2:0] TECH_LINK_OK;
  anxp_link_status_type LINK_STATUS;
  logic [15:0] wv [4] = '{16'hFFFF, 16'h0000, 16'hA555, 16'h5AAA};
  int n_errors = 0, cmp_count = 0;

  always #4 CLK = ~CLK;

  anxp_regs i_anxp_regs (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .PD_ACTIVE(PD_ACTIVE), .TECH_LINK_OK(TECH_LINK_OK),
    .PAGE_RX(PAGE_RX), .NP_START(NP_START), .PAGE_DONE(PAGE_DONE),
    .LINK_STATUS(LINK_STATUS), .TX_PAGE(TX_PAGE));
  anxp_engine_model i_anxp_engine_model (.clk(CLK), .pd_active(PD_ACTIVE),
    .tech_link_ok(TECH_LINK_OK), .page_rx(PAGE_RX), .np_start(NP_START),
    .page_done(PAGE_DONE), .link_status(LINK_STATUS));

  // ==========
  // Bus and check tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [15:0] exp);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
    chk(d, exp);
  endtask

  task automatic tgl(input logic [2:0] p, input logic b, input logic e);
    i_anxp_engine_model.set_status({3'h0, b});
    i_anxp_engine_model.pulse(p);
    @(posedge CLK);
    #1;
    chk({15'h0000, TX_PAGE[11]}, {15'h0000, e});
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  initial begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    #1;
    chk_rd(ANXP_OFF_EXTRA_PAGE, ANXP_RST_EXTRA_PAGE);
    chk_rd(ANXP_OFF_IRQ_MASK, 16'h0000);
    chk_rd(5'h1F, 16'h0000);
    wr(ANXP_OFF_EXPANSION, 16'hFFFF);
    chk_rd(ANXP_OFF_EXPANSION, 16'h0004);
    for (int i = 0; i < 16; i++) begin
      i_anxp_engine_model.set_status(i[3:0]);
      chk_rd(ANXP_OFF_EXPANSION, {11'h000, 1'b0, i[3], 2'b10, i[2]});
      chk_rd(ANXP_OFF_EXTRA_PAGE, {1'b0, i[1], 14'h0000});
    end
    i_anxp_engine_model.set_status(4'h0);
    for (int i = 0; i < 16; i++) begin
      i_anxp_engine_model.detect(i[3], i[2:0]);
      chk_rd(ANXP_OFF_EXPANSION, (i[3] && $countones(i[2:0]) > 1) ? 16'h0014 : 16'h0004);
      chk_rd(ANXP_OFF_EXPANSION, 16'h0004);
    end
    i_anxp_engine_model.pulse(3'b100);
    chk_rd(ANXP_OFF_EXPANSION, 16'h0006);
    chk_rd(ANXP_OFF_EXPANSION, 16'h0004);
    wr(ANXP_OFF_IRQ_MASK, 16'h0002);
    chk_rd(ANXP_OFF_IRQ_STATUS, 16'h0003);
    chk({15'h0000, IRQ}, 16'h0001);
    wr(ANXP_OFF_IRQ_STATUS, 16'h0002);
    chk_rd(ANXP_OFF_IRQ_STATUS, 16'h0001);
    chk({15'h0000, IRQ}, 16'h0000);
    i_anxp_engine_model.pulse(3'b100);
    chk_rd(ANXP_OFF_IRQ_STATUS, 16'h0003);
    chk({15'h0000, IRQ}, 16'h0001);
    wr(ANXP_OFF_IRQ_MASK, 16'h0000);
    wr(ANXP_OFF_IRQ_STATUS, 16'h0003);
    chk_rd(ANXP_OFF_IRQ_STATUS, 16'h0000);
    chk({15'h0000, IRQ}, 16'h0000);
    foreach (wv[k]) begin
      wr(ANXP_OFF_EXTRA_PAGE, wv[k]);
      chk_rd(ANXP_OFF_EXTRA_PAGE, wv[k] & 16'hB7FF);
      chk(TX_PAGE, wv[k] & 16'hB7FF);
    end
    tgl(3'b010, 1'b0, 1'b1);
    tgl(3'b001, 1'b0, 1'b0);
    tgl(3'b001, 1'b0, 1'b1);
    tgl(3'b010, 1'b0, 1'b1);
    tgl(3'b011, 1'b0, 1'b1);
    tgl(3'b010, 1'b1, 1'b0);
    close_out();
  end

  initial begin
    repeat (5000) @(posedge CLK);
    n_errors++;
    close_out();
  end
endmodule // tb

`default_nettype wire
